// ===== ubr_top.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "ubr_regs.svh"
module ubr_top #(
  parameter bit       IR_CAPABLE = 1'b1,
  parameter bit [7:0] MODULE_REV = 8'h5A  // value is arbitrary
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write address
  input  wire logic [`UBR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output wire logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output wire logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read address
  input  wire logic [`UBR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output wire logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // receive and transmit data
  input  wire logic [7:0]             rx_data,
  output logic                        rx_read,
  output logic [7:0]                  tx_data,
  output logic                        tx_load,
  // status from the serial core
  input  wire logic [7:0]             event_identification,
  input  wire logic [7:0]             link_status,
  input  wire logic [7:0]             modem_line_status,
  input  wire logic                   rx_fifo_timeout,
  // control towards the serial core
  output logic [7:0]                  fifo_control,
  output logic                        fifo_control_load,
  output logic [7:0]                  line_control,
  output logic [7:0]                  interrupt_enables,
  output logic [7:0]                  modem_mode_control,
  output logic [15:0]                 legacy_divisor,
  output logic [15:0]                 divisor,
  output logic [7:0]                  extended_control_one,
  output logic [7:0]                  extended_control_two,
  output logic [7:0]                  tx_fifo_fill,
  output logic [7:0]                  rx_fifo_fill,
  output logic [7:0]                  scratch_byte,
  output ubr_pkg::ubr_bank_t          active_bank,
  // interrupt
  output wire logic                   irq
);
  import ubr_pkg::*;

  // register index from a byte address
  function automatic logic [3:0] idx_of(input logic [`UBR_ADDR_W-1:0] addr);
    idx_of = addr[5:2];
  endfunction : idx_of

  // index lies inside the map
  function automatic logic mapped(input logic [3:0] idx);
    mapped = (idx <= `UBR_IDX_INT_MASK);
  endfunction : mapped

  logic [3:0]           aw_idx;
  logic                 aw_held;
  logic [7:0]           w_byte;
  logic                 w_lane0;
  logic                 w_held;
  logic                 do_write;
  logic                 wr_en;
  logic                 rd_take;
  logic [3:0]           ar_idx;
  logic                 extended;
  logic                 rx_fifo_timeout_flag;
  logic [`UBR_EV_W-1:0] int_status;
  logic [`UBR_EV_W-1:0] int_mask;
  logic [`UBR_EV_W-1:0] next_int_status;
  logic                 next_timeout_flag;
  logic [7:0]           read_byte;
  logic                 wr_b0;
  logic                 wr_b1;
  logic                 wr_b2;
  logic                 wr_b3;
  logic                 tout_clear;

  // bank follows the line control/bank select byte
  ubr_bank_decode #(
    .IR_CAPABLE (IR_CAPABLE)
  ) u_bank_decode (
    .select_byte (line_control),
    .bank        (active_bank)
  );

  assign extended = extended_control_one[`UBR_EXT_BIT];

  // write channels accept independently while no response is pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_en         = do_write && w_lane0 && mapped(aw_idx);

  // hold write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx  <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx  <= idx_of(s_axi_awaddr);
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // hold write data, only the low lane carries a register byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `UBR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_idx) ? `UBR_RESP_OKAY : `UBR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // per-bank write strobes at shared offsets
  assign wr_b0 = wr_en && (active_bank == UBR_BANK0);
  assign wr_b1 = wr_en && (active_bank == UBR_BANK1);
  assign wr_b2 = wr_en && (active_bank == UBR_BANK2);
  assign wr_b3 = wr_en && (active_bank == UBR_BANK3);

  // line control/bank select sits at offset 3 in every bank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_control <= `UBR_RST_BYTE;
    end else if (wr_en && aw_idx == `UBR_IDX_LINE) begin
      line_control <= w_byte;
    end
  end

  // transmit byte and its load strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_data <= `UBR_RST_BYTE;
      tx_load <= 1'b0;
    end else begin
      tx_load <= wr_b0 && aw_idx == `UBR_IDX_DATA;
      if (wr_b0 && aw_idx == `UBR_IDX_DATA) begin
        tx_data <= w_byte;
      end
    end
  end

  // fifo control, write-only in bank 0, mirrored in bank 3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fifo_control      <= `UBR_RST_BYTE;
      fifo_control_load <= 1'b0;
    end else begin
      fifo_control_load <= wr_b0 && aw_idx == `UBR_IDX_EVENT;
      if (wr_b0 && aw_idx == `UBR_IDX_EVENT) begin
        fifo_control <= w_byte;
      end
    end
  end

  // bank 0 read/write controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_enables  <= `UBR_RST_BYTE;
      modem_mode_control <= `UBR_RST_BYTE;
      scratch_byte       <= `UBR_RST_BYTE;
    end else begin
      if (wr_b0 && aw_idx == `UBR_IDX_ENABLES) begin
        interrupt_enables <= w_byte;
      end
      if (wr_b0 && aw_idx == `UBR_IDX_MODEM) begin
        modem_mode_control <= w_byte;
      end
      if (wr_b0 && aw_idx == `UBR_IDX_SCR && !extended) begin
        scratch_byte <= w_byte;
      end
    end
  end

  // legacy divisor in bank 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      legacy_divisor <= `UBR_RST_DIV;
    end else begin
      if (wr_b1 && aw_idx == `UBR_IDX_DATA) begin
        legacy_divisor[7:0] <= w_byte;
      end
      if (wr_b1 && aw_idx == `UBR_IDX_ENABLES) begin
        legacy_divisor[15:8] <= w_byte;
      end
    end
  end

  // second divisor and extended controls in bank 2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divisor              <= `UBR_RST_DIV;
      extended_control_one <= `UBR_RST_BYTE;
      extended_control_two <= `UBR_RST_BYTE;
      tx_fifo_fill         <= `UBR_RST_BYTE;
      rx_fifo_fill         <= `UBR_RST_BYTE;
    end else if (wr_b2) begin
      case (aw_idx)
        `UBR_IDX_DATA: divisor[7:0]         <= w_byte;
        `UBR_IDX_ENABLES:  divisor[15:8]        <= w_byte;
        `UBR_IDX_EVENT:    extended_control_one <= w_byte;
        `UBR_IDX_MODEM:    extended_control_two <= w_byte;
        `UBR_IDX_MODEM_ST: tx_fifo_fill         <= w_byte;
        `UBR_IDX_SCR:  rx_fifo_fill         <= w_byte;
        default:       ;
      endcase
    end
  end

  // timeout flag: set by the core, write one clears, set wins
  assign tout_clear = wr_b0 && aw_idx == `UBR_IDX_SCR && extended && w_byte[`UBR_TOUT_BIT];

  always_comb begin
    next_timeout_flag = rx_fifo_timeout_flag;
    if (tout_clear) begin
      next_timeout_flag = 1'b0;
    end
    if (rx_fifo_timeout) begin
      next_timeout_flag = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_fifo_timeout_flag <= 1'b0;
    end else begin
      rx_fifo_timeout_flag <= next_timeout_flag;
    end
  end

  // sticky interrupt status, write one clears, set wins
  always_comb begin
    next_int_status = int_status;
    if (wr_en && aw_idx == `UBR_IDX_INT_STAT) begin
      next_int_status = int_status & ~w_byte[`UBR_EV_W-1:0];
    end
    next_int_status[`UBR_EV_TOUT]   = next_int_status[`UBR_EV_TOUT] | rx_fifo_timeout;
    next_int_status[`UBR_EV_TXLOAD] = next_int_status[`UBR_EV_TXLOAD] | tx_load;
    next_int_status[`UBR_EV_RXREAD] = next_int_status[`UBR_EV_RXREAD] | rx_read;
  end

  // interrupt status and mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= `UBR_RST_EV;
      int_mask   <= `UBR_RST_EV;
    end else begin
      int_status <= next_int_status;
      if (wr_en && aw_idx == `UBR_IDX_INT_MASK) begin
        int_mask <= w_byte[`UBR_EV_W-1:0];
      end
    end
  end

  assign irq = |(int_status & int_mask);

  // read channel accepts one request while no data is pending
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign ar_idx        = idx_of(s_axi_araddr);

  // read multiplexer over the active bank
  always_comb begin
    read_byte = 8'h00;
    if (ar_idx == `UBR_IDX_LINE) begin
      read_byte = line_control;
    end else if (ar_idx == `UBR_IDX_INT_STAT) begin
      read_byte = {5'h00, int_status};
    end else if (ar_idx == `UBR_IDX_INT_MASK) begin
      read_byte = {5'h00, int_mask};
    end else begin
      case (active_bank)
        UBR_BANK0: begin
          case (ar_idx)
            `UBR_IDX_DATA: read_byte = rx_data;
            `UBR_IDX_ENABLES:  read_byte = interrupt_enables;
            `UBR_IDX_EVENT:    read_byte = event_identification;
            `UBR_IDX_MODEM:    read_byte = modem_mode_control;
            `UBR_IDX_LINK:     read_byte = link_status;
            `UBR_IDX_MODEM_ST: read_byte = modem_line_status;
            `UBR_IDX_SCR:  read_byte = extended ? {7'h00, rx_fifo_timeout_flag}
                                                : scratch_byte;
            default:       read_byte = 8'h00;
          endcase
        end
        UBR_BANK1: begin
          case (ar_idx)
            `UBR_IDX_DATA: read_byte = legacy_divisor[7:0];
            `UBR_IDX_ENABLES: read_byte = legacy_divisor[15:8];
            default:       read_byte = 8'h00;
          endcase
        end
        UBR_BANK2: begin
          case (ar_idx)
            `UBR_IDX_DATA: read_byte = divisor[7:0];
            `UBR_IDX_ENABLES:  read_byte = divisor[15:8];
            `UBR_IDX_EVENT:    read_byte = extended_control_one;
            `UBR_IDX_MODEM:    read_byte = extended_control_two;
            `UBR_IDX_MODEM_ST: read_byte = tx_fifo_fill;
            `UBR_IDX_SCR:  read_byte = rx_fifo_fill;
            default:       read_byte = 8'h00;
          endcase
        end
        UBR_BANK3: begin
          case (ar_idx)
            `UBR_IDX_DATA: read_byte = MODULE_REV;
            `UBR_IDX_ENABLES: read_byte = line_control;
            `UBR_IDX_EVENT:   read_byte = fifo_control;
            default:       read_byte = 8'h00;
          endcase
        end
        default: read_byte = 8'h00;
      endcase
    end
  end

  // read data, response and receive-read strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `UBR_RESP_OKAY;
      rx_read      <= 1'b0;
    end else begin
      rx_read <= rd_take && ar_idx == `UBR_IDX_DATA && active_bank == UBR_BANK0;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, read_byte};
        s_axi_rresp  <= mapped(ar_idx) ? `UBR_RESP_OKAY : `UBR_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // bank decoding of unlisted patterns leaves only offsets 3, 8 and 9 live
  // banks 4-7 exist for decoding only; their registers read zero
endmodule : ubr_top

// ===== ubr_regs.svh
`ifndef UBR_REGS_SVH
`define UBR_REGS_SVH

// register indices; byte address is four times the index
`define UBR_IDX_DATA      4'h0
`define UBR_IDX_ENABLES   4'h1
`define UBR_IDX_EVENT     4'h2
`define UBR_IDX_LINE      4'h3
`define UBR_IDX_MODEM     4'h4
`define UBR_IDX_LINK      4'h5
`define UBR_IDX_MODEM_ST  4'h6
`define UBR_IDX_SCR       4'h7
`define UBR_IDX_INT_STAT  4'h8
`define UBR_IDX_INT_MASK  4'h9

// bus geometry
`define UBR_ADDR_W        6

// field positions
`define UBR_BANK_EN_BIT   7
`define UBR_EXT_BIT       0
`define UBR_TOUT_BIT      0
`define UBR_EV_TOUT       0
`define UBR_EV_TXLOAD     1
`define UBR_EV_RXREAD     2
`define UBR_EV_W          3

// reset values
`define UBR_RST_BYTE      8'h00
`define UBR_RST_DIV       16'h0000
`define UBR_RST_EV        3'h0

// bus responses
`define UBR_RESP_OKAY     2'h0
`define UBR_RESP_SLVERR   2'h2

`endif

// ===== ubr_pkg.sv
package ubr_pkg;
  // active register bank, one-hot
  typedef enum logic [8:0] {
    UBR_BANK0     = 9'h001,
    UBR_BANK1     = 9'h002,
    UBR_BANK2     = 9'h004,
    UBR_BANK3     = 9'h008,
    UBR_BANK4     = 9'h010,
    UBR_BANK5     = 9'h020,
    UBR_BANK6     = 9'h040,
    UBR_BANK7     = 9'h080,
    UBR_BANK_NONE = 9'h100
  } ubr_bank_t;
endpackage : ubr_pkg

// ===== ubr_bank_decode.sv
`timescale 1ns/1ns
module ubr_bank_decode #(
  parameter bit IR_CAPABLE = 1'b1
) (
  // select byte in
  input  wire logic [7:0]        select_byte,
  // decoded bank out
  output ubr_pkg::ubr_bank_t     bank
);
  import ubr_pkg::*;

  ubr_bank_t raw_bank;

  // map the select byte onto a bank
  always_comb begin
    raw_bank = UBR_BANK_NONE;
    if (!select_byte[7]) begin
      raw_bank = UBR_BANK0;
    end else if (!select_byte[6] || select_byte[1] || select_byte[0]) begin
      raw_bank = UBR_BANK1;
    end else begin
      case (select_byte[5:0])
        6'h20:   raw_bank = UBR_BANK2;
        6'h24:   raw_bank = UBR_BANK3;
        6'h28:   raw_bank = UBR_BANK4;
        6'h2C:   raw_bank = UBR_BANK5;
        6'h30:   raw_bank = UBR_BANK6;
        6'h34:   raw_bank = UBR_BANK7;
        default: raw_bank = UBR_BANK_NONE;
      endcase
    end
  end

  // infrared banks vanish on a port without infrared
  always_comb begin
    bank = raw_bank;
    if (!IR_CAPABLE && (raw_bank == UBR_BANK4 || raw_bank == UBR_BANK5 ||
                        raw_bank == UBR_BANK6 || raw_bank == UBR_BANK7)) begin
      bank = UBR_BANK_NONE;
    end
  end
endmodule : ubr_bank_decode

// ===== ubr_top_checker.sv
`timescale 1ns/1ns
`include "ubr_regs.svh"
module ubr_top_checker (
  // clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // bus answers
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_rvalid,
  // core side
  input wire logic         rx_read,
  input wire logic         tx_load,
  input wire logic [7:0]   tx_data,
  input wire logic [7:0]   fifo_control,
  input wire logic         fifo_control_load,
  input wire logic [7:0]   line_control,
  input wire logic [15:0]  legacy_divisor,
  input wire logic [15:0]  divisor,
  input ubr_pkg::ubr_bank_t active_bank,
  input wire logic         irq
);
  import ubr_pkg::*;
  // one clock domain, reset disables every check
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bank decode from the select byte
  a_bank_zero_clear: assert property (!line_control[7] |-> active_bank == UBR_BANK0)
    else $error("bank not zero with select bit clear");
  a_bank_one_decode: assert property (
    line_control[7] && (!line_control[6] || line_control[1:0] != 2'h0)
    |-> active_bank == UBR_BANK1)
    else $error("bank one pattern misdecoded");
  a_bank_two_three: assert property (
    line_control inside {8'hE0, 8'hE4}
    |-> active_bank == (line_control[2] ? UBR_BANK3 : UBR_BANK2))
    else $error("bank two or three misdecoded");
  a_bank_ir_only: assert property (line_control == 8'hF4 |-> active_bank == UBR_BANK7)
    else $error("infrared bank misdecoded");
  // data port side effects tied to bus answers
  a_tx_load_answer: assert property (
    tx_load |-> $rose(s_axi_bvalid) && active_bank == UBR_BANK0)
    else $error("transmit load without bank zero write");
  // a reset edge clears held bytes, so the cycle after reset is excused
  a_tx_data_cause: assert property (
    $past(aresetn) && !tx_load |-> $stable(tx_data))
    else $error("transmit byte moved without load");
  a_rx_read_answer: assert property (
    rx_read |-> $rose(s_axi_rvalid) && active_bank == UBR_BANK0)
    else $error("receive pulse without bank zero read");
  a_fifo_load_pulse: assert property (
    fifo_control_load |-> $rose(s_axi_bvalid) ##1 !fifo_control_load)
    else $error("fifo control load not a single pulse");
  a_fifo_ctrl_hold: assert property (
    $past(aresetn) && !fifo_control_load |-> $stable(fifo_control))
    else $error("fifo control moved without load");
  // divisors only move on writes in their own bank, or on a reset edge
  a_legacy_div_bank: assert property (
    $past(aresetn) && $changed(legacy_divisor)
    |-> $rose(s_axi_bvalid) && active_bank == UBR_BANK1)
    else $error("legacy divisor moved outside bank one");
  a_second_div_bank: assert property (
    $past(aresetn) && $changed(divisor)
    |-> $rose(s_axi_bvalid) && active_bank == UBR_BANK2)
    else $error("divisor moved outside bank two");
  // main scenarios reached
  c_rx_read: cover property (rx_read);
  c_tx_load: cover property (tx_load);
  c_irq_rise: cover property ($rose(irq));
  c_bank_seven: cover property (active_bank == UBR_BANK7);
endmodule : ubr_top_checker

bind ubr_top ubr_top_checker i_checker (.aclk, .aresetn, .s_axi_bvalid, .s_axi_rvalid,
  .rx_read, .tx_load, .tx_data, .fifo_control, .fifo_control_load, .line_control,
  .legacy_divisor, .divisor, .active_bank, .irq);

// ===== tb_top.sv
`timescale 1ns/1ns
`include "ubr_regs.svh"
module tb_top;
  import ubr_pkg::*;
  typedef struct packed {logic wr; logic [3:0] idx; logic [7:0] d;} ubr_row_t;
  // design ports
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [`UBR_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] rx_data, tx_data, fifo_control, line_control, interrupt_enables, rd;
  logic [7:0] modem_mode_control, extended_control_one, extended_control_two;
  logic [7:0] tx_fifo_fill, rx_fifo_fill, scratch_byte;
  logic rx_read, tx_load, fifo_control_load, rx_fifo_timeout, irq;
  logic [15:0] legacy_divisor, divisor;
  ubr_bank_t active_bank;
  int err_count, checks, cycles, n_tx, n_rx;
  // ordinary accesses: write rows load, read rows carry the expected byte
  ubr_row_t rows [38] = '{'{1,3,8'h03}, '{0,3,8'h03}, '{1,1,8'hA5}, '{0,1,8'hA5},
    '{1,2,8'hC7}, '{0,2,8'h3C}, '{0,5,8'h61}, '{0,6,8'h92}, '{1,7,8'h5B}, '{0,7,8'h5B},
    '{1,4,8'h3E}, '{0,4,8'h3E},
    '{1,3,8'h80}, '{0,3,8'h80}, '{1,0,8'h12}, '{1,1,8'h34}, '{0,0,8'h12}, '{0,1,8'h34},
    '{1,3,8'hE0}, '{1,0,8'h56}, '{1,1,8'h78}, '{0,0,8'h56}, '{0,1,8'h78}, '{1,2,8'h01},
    '{0,2,8'h01}, '{1,4,8'h2B}, '{1,6,8'h0F}, '{1,7,8'h1D}, '{0,4,8'h2B}, '{0,6,8'h0F},
    '{0,7,8'h1D},
    '{1,3,8'hE4}, '{0,0,8'h5A}, '{0,1,8'hE4}, '{0,2,8'hC7}, '{0,3,8'hE4}, '{1,3,8'h00},
    '{0,7,8'h00}};
  logic [7:0] sel_v [11] = '{8'h7F, 8'hBF, 8'hC2, 8'hC1, 8'hE0, 8'hE4, 8'hE8, 8'hEC,
    8'hF0, 8'hF4, 8'hC0};
  ubr_bank_t bank_v [11] = '{UBR_BANK0, UBR_BANK1, UBR_BANK1, UBR_BANK1, UBR_BANK2,
    UBR_BANK3, UBR_BANK4, UBR_BANK5, UBR_BANK6, UBR_BANK7, UBR_BANK_NONE};

  ubr_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_data, .rx_read, .tx_data, .tx_load,
    .event_identification(8'h3C), .link_status(8'h61), .modem_line_status(8'h92),
    .rx_fifo_timeout, .fifo_control, .fifo_control_load, .line_control, .interrupt_enables,
    .modem_mode_control, .legacy_divisor, .divisor, .extended_control_one,
    .extended_control_two, .tx_fifo_fill, .rx_fifo_fill, .scratch_byte, .active_bank, .irq);

  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // pulses are counted mid-cycle so a task ending on an edge sees them
  always @(negedge aclk) begin
    cycles++;
    if (tx_load === 1'b1) n_tx++;
    if (rx_read === 1'b1) n_rx++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // write: address and data offered together, each released once taken
  task automatic axi_write(input logic [3:0] idx, input logic [7:0] d, input logic [3:0] s);
    logic a, w, b;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (b !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] idx);
    logic a, r;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rd = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
    end while (r !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {rx_data, rx_fifo_timeout, aresetn} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) axi_write(rows[i].idx, rows[i].d, 4'hF);
      else begin
        axi_read(rows[i].idx);
        chk(rd, rows[i].d);
      end
    end
    chk(legacy_divisor, 16'h3412);
    chk(divisor, 16'h7856);
    chk(fifo_control, 8'hC7);
    chk({interrupt_enables, modem_mode_control, scratch_byte, extended_control_two},
      {8'hA5, 8'h3E, 8'h5B, 8'h2B});
    chk({tx_fifo_fill, rx_fifo_fill, extended_control_one}, {8'h0F, 8'h1D, 8'h01});
    chk(n_tx + n_rx, 0);
    end_test("table");
    foreach (sel_v[i]) begin
      axi_write(`UBR_IDX_LINE, sel_v[i], 4'hF);
      chk(active_bank, bank_v[i]);
    end
    end_test("decode");
    axi_write(`UBR_IDX_LINE, 8'h00, 4'hF);
    axi_write(`UBR_IDX_DATA, 8'h9E, 4'hF);
    rx_data <= 8'h4D;
    axi_read(`UBR_IDX_DATA);
    chk(rd, 8'h4D);
    chk(tx_data, 8'h9E);
    chk({n_tx[15:0], n_rx[15:0]}, {16'd1, 16'd1});
    end_test("data ports");
    axi_write(`UBR_IDX_INT_STAT, 8'h07, 4'hF);
    @(posedge aclk) rx_fifo_timeout <= 1'b1;
    @(posedge aclk) rx_fifo_timeout <= 1'b0;
    axi_read(`UBR_IDX_SCR);
    chk(rd, 8'h01);
    axi_read(`UBR_IDX_INT_STAT);
    chk({rd, irq}, {8'h01, 1'b0});
    axi_write(`UBR_IDX_INT_MASK, 8'h01, 4'hF);
    chk(irq, 1'b1);
    axi_write(`UBR_IDX_INT_STAT, 8'h01, 4'hF);
    chk(irq, 1'b0);
    axi_write(`UBR_IDX_SCR, 8'h01, 4'h0);
    axi_read(`UBR_IDX_SCR);
    chk(rd, 8'h01);
    axi_write(`UBR_IDX_SCR, 8'h01, 4'hF);
    axi_read(`UBR_IDX_SCR);
    chk(rd, 8'h00);
    end_test("events");
    axi_write(4'hA, 8'h11, 4'hF);
    chk(resp, `UBR_RESP_SLVERR);
    axi_read(4'hF);
    chk(resp, `UBR_RESP_SLVERR);
    end_test("unmapped");
    axi_write(`UBR_IDX_LINE, 8'h80, 4'hF);
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`UBR_IDX_LINE);
    chk(rd, 8'h00);
    chk({active_bank, irq, legacy_divisor}, {UBR_BANK0, 1'b0, 16'h0000});
    end_test("reset");
    give_verdict();
  end
endmodule : tb_top
